// ---- shared/fct_defines.svh ----
// Offsets, codes and counts of the cyclic telegram and acyclic access
`ifndef FCT_DEFINES_SVH
`define FCT_DEFINES_SVH
`define FCT_IN_PRI_VAL 4'h0
`define FCT_IN_PRI_STAT 4'h4
`define FCT_IN_SEC_VAL 4'h5
`define FCT_IN_SEC_STAT 4'h9
`define FCT_IN_LEN_PRI 4'h5
`define FCT_IN_LEN_BOTH 4'ha
`define FCT_OUT_LEN 4'h5
`define FCT_FLOAT_BIAS 8'h7f
`define FCT_ST_SEC_DEV_ERR 8'h0c
`define FCT_ST_PRI_DEV_ERR 8'h0f
`define FCT_ST_PRI_OOS 8'h1f
`define FCT_ST_SEC_SIM 8'h40
`define FCT_ST_PRI_LAST 8'h47
`define FCT_ST_PRI_SUBST 8'h4b
`define FCT_ST_PRI_INIT 8'h4f
`define FCT_ST_PRI_LIMCFG 8'h5c
`define FCT_ST_OK 8'h80
`define FCT_ST_BLK_ALARM 8'h84
`define FCT_ST_LO 8'h89
`define FCT_ST_HI 8'h8a
`define FCT_ST_LOLO 8'h8d
`define FCT_ST_HIHI 8'h8e
`define FCT_GOOD_MASK 8'hc0
`define FCT_GOOD_VAL 8'h80
`define FCT_SAP_MS1AC 8'h33
`define FCT_MS2AC_SAPS 2
`endif

// ---- shared/fct_pkg.sv ----
// Types for the cyclic telegram framer
package fct_pkg;
    // Module kinds that may sit in a configuration slot
    typedef enum logic [1:0] {
        FCT_MOD_PRIMARY,
        FCT_MOD_SECONDARY,
        FCT_MOD_DISPLAY,
        FCT_MOD_FILLER
    } fct_mod_e;
    typedef enum logic [3:0] {
        FCT_PS_PRI_OK,
        FCT_PS_PRI_DEV_ERR,
        FCT_PS_PRI_OOS,
        FCT_PS_PRI_LAST,
        FCT_PS_PRI_SUBST,
        FCT_PS_PRI_INIT,
        FCT_PS_PRI_LIMCFG,
        FCT_PS_PRI_BLK_ALARM,
        FCT_PS_PRI_LO,
        FCT_PS_PRI_HI,
        FCT_PS_PRI_LOLO,
        FCT_PS_PRI_HIHI
    } fct_pri_cond_e;
    typedef enum logic [1:0] {
        FCT_SC_OK,
        FCT_SC_DEV_ERR,
        FCT_SC_SIM
    } fct_sec_cond_e;
endpackage

// ---- shared/fct_link_if.sv ----
// Link between the transmitter end and the master end
`timescale 1ns/1ps
`default_nettype none
interface fct_link_if;
    // Configuration: three slots, sent by master, valid with cfg_valid
    fct_pkg::fct_mod_e cfg_slot0;
    fct_pkg::fct_mod_e cfg_slot1;
    fct_pkg::fct_mod_e cfg_slot2;
    logic cfg_valid;
    logic cfg_ok;
    // Input telegram bytes, device to master
    logic in_valid;
    logic [3:0] in_index;
    logic [7:0] in_byte;
    logic in_last;
    // Output telegram bytes, master to device
    logic out_valid;
    logic [3:0] out_index;
    logic [7:0] out_byte;
    logic out_last;
    // Acyclic session request and answer
    logic ac_req;
    logic [7:0] ac_sap;
    logic ac_open;
    logic ac_close;
    logic [7:0] ac_slot;
    logic [7:0] ac_index;
    logic ac_ack;
    logic ac_accept;
    modport device (
        input cfg_slot0, cfg_slot1, cfg_slot2, cfg_valid, out_valid, out_index, out_byte, out_last,
        input ac_req, ac_sap, ac_open, ac_close, ac_slot, ac_index,
        output cfg_ok, in_valid, in_index, in_byte, in_last, ac_ack, ac_accept
    );
    modport master (
        output cfg_slot0, cfg_slot1, cfg_slot2, cfg_valid, out_valid, out_index, out_byte, out_last,
        output ac_req, ac_sap, ac_open, ac_close, ac_slot, ac_index,
        input cfg_ok, in_valid, in_index, in_byte, in_last, ac_ack, ac_accept
    );
endinterface
`default_nettype wire

// ---- rtl/fct_device.sv ----
// Transmitter end: builds input telegram, parses display telegram, gates acyclic sessions
`timescale 1ns/1ps
`default_nettype none
`include "fct_defines.svh"
module fct_device (
    input wire logic clk,
    input wire logic rstn,
    fct_link_if.device link,
    input wire logic [31:0] pri_value,
    input wire fct_pkg::fct_pri_cond_e pri_cond,
    input wire logic [31:0] sec_value,
    input wire fct_pkg::fct_sec_cond_e sec_cond,
    input wire logic send_start,
    output logic busy,
    output logic sec_enabled,
    output logic disp_enabled,
    output logic [31:0] disp_value,
    output logic [7:0] disp_status,
    output logic disp_error,
    output logic disp_update,
    output logic ac_grant,
    output logic [7:0] ac_slot_out,
    output logic [7:0] ac_index_out,
    output logic [1:0] sessions
);
    // ----------------------------------------
    // Status encoding
    // ----------------------------------------
    function automatic logic [7:0] pri_code(input fct_pkg::fct_pri_cond_e c);
        case (c)
            fct_pkg::FCT_PS_PRI_DEV_ERR: pri_code = `FCT_ST_PRI_DEV_ERR;
            fct_pkg::FCT_PS_PRI_OOS: pri_code = `FCT_ST_PRI_OOS;
            fct_pkg::FCT_PS_PRI_LAST: pri_code = `FCT_ST_PRI_LAST;
            fct_pkg::FCT_PS_PRI_SUBST: pri_code = `FCT_ST_PRI_SUBST;
            fct_pkg::FCT_PS_PRI_INIT: pri_code = `FCT_ST_PRI_INIT;
            fct_pkg::FCT_PS_PRI_LIMCFG: pri_code = `FCT_ST_PRI_LIMCFG;
            fct_pkg::FCT_PS_PRI_BLK_ALARM: pri_code = `FCT_ST_BLK_ALARM;
            fct_pkg::FCT_PS_PRI_LO: pri_code = `FCT_ST_LO;
            fct_pkg::FCT_PS_PRI_HI: pri_code = `FCT_ST_HI;
            fct_pkg::FCT_PS_PRI_LOLO: pri_code = `FCT_ST_LOLO;
            fct_pkg::FCT_PS_PRI_HIHI: pri_code = `FCT_ST_HIHI;
            default: pri_code = `FCT_ST_OK;
        endcase
    endfunction
    function automatic logic [7:0] sec_code(input fct_pkg::fct_sec_cond_e c);
        case (c)
            fct_pkg::FCT_SC_DEV_ERR: sec_code = `FCT_ST_SEC_DEV_ERR;
            fct_pkg::FCT_SC_SIM: sec_code = `FCT_ST_SEC_SIM;
            default: sec_code = `FCT_ST_OK;
        endcase
    endfunction

    // ----------------------------------------
    // Configuration check
    // ----------------------------------------
    logic sec_enabled_next, disp_enabled_next, cfg_ok_reg, cfg_ok_next;
    always_comb begin
        sec_enabled_next = sec_enabled;
        disp_enabled_next = disp_enabled;
        cfg_ok_next = cfg_ok_reg;
        if (link.cfg_valid) begin
            cfg_ok_next = 1'b0;
            if (link.cfg_slot0 == fct_pkg::FCT_MOD_PRIMARY) begin
                if (link.cfg_slot1 == fct_pkg::FCT_MOD_FILLER && link.cfg_slot2 == fct_pkg::FCT_MOD_FILLER) begin
                    cfg_ok_next = 1'b1;
                    sec_enabled_next = 1'b0;
                    disp_enabled_next = 1'b0;
                end else if (link.cfg_slot1 == fct_pkg::FCT_MOD_SECONDARY
                             && link.cfg_slot2 == fct_pkg::FCT_MOD_FILLER) begin
                    cfg_ok_next = 1'b1;
                    sec_enabled_next = 1'b1;
                    disp_enabled_next = 1'b0;
                end else if (link.cfg_slot1 == fct_pkg::FCT_MOD_FILLER
                             && link.cfg_slot2 == fct_pkg::FCT_MOD_DISPLAY) begin
                    cfg_ok_next = 1'b1;
                    sec_enabled_next = 1'b0;
                    disp_enabled_next = 1'b1;
                end else if (link.cfg_slot1 == fct_pkg::FCT_MOD_SECONDARY
                             && link.cfg_slot2 == fct_pkg::FCT_MOD_DISPLAY) begin
                    cfg_ok_next = 1'b1;
                    sec_enabled_next = 1'b1;
                    disp_enabled_next = 1'b1;
                end
            end
            // A rejected layout keeps the previous telegram shape
        end
    end

    // ----------------------------------------
    // Input telegram serializer
    // ----------------------------------------
    logic [79:0] frame_reg, frame_next;
    logic [3:0] idx_reg, idx_next, len_reg, len_next;
    logic busy_next, in_valid_reg, in_valid_next, in_last_reg, in_last_next;
    logic [7:0] in_byte_reg, in_byte_next;
    logic [3:0] in_index_reg, in_index_next;
    always_comb begin
        frame_next = frame_reg;
        idx_next = idx_reg;
        len_next = len_reg;
        busy_next = busy;
        in_valid_next = 1'b0;
        in_last_next = 1'b0;
        in_byte_next = in_byte_reg;
        in_index_next = in_index_reg;
        if (!busy && send_start) begin
            // Snapshot so a value changing mid-telegram cannot tear a float
            frame_next = {pri_value, pri_code(pri_cond), sec_value, sec_code(sec_cond)};
            len_next = sec_enabled ? `FCT_IN_LEN_BOTH : `FCT_IN_LEN_PRI;
            idx_next = 4'h0;
            busy_next = 1'b1;
        end else if (busy) begin
            in_valid_next = 1'b1;
            in_index_next = idx_reg;
            in_byte_next = frame_reg[79:72];
            frame_next = {frame_reg[71:0], 8'h00};
            in_last_next = (idx_reg == len_reg - 4'h1);
            idx_next = idx_reg + 4'h1;
            if (idx_reg == len_reg - 4'h1) begin
                busy_next = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Display telegram parser
    // ----------------------------------------
    logic [31:0] disp_value_next, disp_acc_reg, disp_acc_next;
    logic [7:0] disp_status_next;
    logic disp_error_next, disp_update_next;
    always_comb begin
        disp_acc_next = disp_acc_reg;
        disp_value_next = disp_value;
        disp_status_next = disp_status;
        disp_error_next = disp_error;
        disp_update_next = 1'b0;
        if (link.out_valid && disp_enabled) begin
            if (link.out_index < `FCT_IN_PRI_STAT) begin
                disp_acc_next = {disp_acc_reg[23:0], link.out_byte};
            end else if (link.out_index == `FCT_IN_PRI_STAT) begin
                disp_value_next = disp_acc_reg;
                disp_status_next = link.out_byte;
                disp_error_next = (link.out_byte & `FCT_GOOD_MASK) != `FCT_GOOD_VAL;
                disp_update_next = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Acyclic session gate
    // ----------------------------------------
    logic [1:0] sessions_next;
    logic ac_ack_reg, ac_ack_next, ac_accept_reg, ac_accept_next, ac_grant_next;
    logic [7:0] ac_slot_next, ac_index_next;
    always_comb begin
        sessions_next = sessions;
        ac_ack_next = 1'b0;
        ac_accept_next = 1'b0;
        ac_grant_next = 1'b0;
        ac_slot_next = ac_slot_out;
        ac_index_next = ac_index_out;
        if (link.ac_req) begin
            ac_ack_next = 1'b1;
            if (link.ac_sap == `FCT_SAP_MS1AC) begin
                ac_accept_next = 1'b0;
            end else if (link.ac_open) begin
                if (sessions < 2'(`FCT_MS2AC_SAPS)) begin
                    sessions_next = sessions + 2'h1;
                    ac_accept_next = 1'b1;
                end
            end else if (link.ac_close) begin
                if (sessions != 2'h0) begin
                    sessions_next = sessions - 2'h1;
                    ac_accept_next = 1'b1;
                end
            end else if (sessions != 2'h0) begin
                ac_accept_next = 1'b1;
                ac_grant_next = 1'b1;
                ac_slot_next = link.ac_slot;
                ac_index_next = link.ac_index;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sec_enabled <= 1'b0;
            disp_enabled <= 1'b0;
            cfg_ok_reg <= 1'b0;
            frame_reg <= 80'h0;
            idx_reg <= 4'h0;
            len_reg <= `FCT_IN_LEN_PRI;
            busy <= 1'b0;
            in_valid_reg <= 1'b0;
            in_last_reg <= 1'b0;
            in_byte_reg <= 8'h00;
            in_index_reg <= 4'h0;
            disp_acc_reg <= 32'h0;
            disp_value <= 32'h0;
            disp_status <= 8'h00;
            disp_error <= 1'b0;
            disp_update <= 1'b0;
            sessions <= 2'h0;
            ac_ack_reg <= 1'b0;
            ac_accept_reg <= 1'b0;
            ac_grant <= 1'b0;
            ac_slot_out <= 8'h00;
            ac_index_out <= 8'h00;
        end else begin
            sec_enabled <= sec_enabled_next;
            disp_enabled <= disp_enabled_next;
            cfg_ok_reg <= cfg_ok_next;
            frame_reg <= frame_next;
            idx_reg <= idx_next;
            len_reg <= len_next;
            busy <= busy_next;
            in_valid_reg <= in_valid_next;
            in_last_reg <= in_last_next;
            in_byte_reg <= in_byte_next;
            in_index_reg <= in_index_next;
            disp_acc_reg <= disp_acc_next;
            disp_value <= disp_value_next;
            disp_status <= disp_status_next;
            disp_error <= disp_error_next;
            disp_update <= disp_update_next;
            sessions <= sessions_next;
            ac_ack_reg <= ac_ack_next;
            ac_accept_reg <= ac_accept_next;
            ac_grant <= ac_grant_next;
            ac_slot_out <= ac_slot_next;
            ac_index_out <= ac_index_next;
        end
    end

    assign link.cfg_ok = cfg_ok_reg;
    assign link.in_valid = in_valid_reg;
    assign link.in_index = in_index_reg;
    assign link.in_byte = in_byte_reg;
    assign link.in_last = in_last_reg;
    assign link.ac_ack = ac_ack_reg;
    assign link.ac_accept = ac_accept_reg;
endmodule
`default_nettype wire

// ---- rtl/fct_master.sv ----
// Master end: configures slots, sends display telegram, collects input telegram
`timescale 1ns/1ps
`default_nettype none
`include "fct_defines.svh"
module fct_master (
    input wire logic clk,
    input wire logic rstn,
    fct_link_if.master link,
    input wire logic want_sec,
    input wire logic want_disp,
    input wire logic cfg_start,
    input wire logic [31:0] disp_value,
    input wire logic [7:0] disp_status,
    input wire logic disp_send,
    output logic disp_busy,
    output logic [31:0] pri_value,
    output logic [7:0] pri_status,
    output logic [31:0] sec_value,
    output logic [7:0] sec_status,
    output logic rx_done,
    output logic cfg_ok
);
    // ----------------------------------------
    // Configuration
    // ----------------------------------------
    fct_pkg::fct_mod_e s1_reg, s1_next, s2_reg, s2_next;
    logic cfg_valid_reg, cfg_valid_next, cfg_ok_next;
    always_comb begin
        s1_next = s1_reg;
        s2_next = s2_reg;
        cfg_valid_next = 1'b0;
        cfg_ok_next = link.cfg_ok;
        if (cfg_start) begin
            // Filler holds the place of whatever is not wanted
            s1_next = want_sec ? fct_pkg::FCT_MOD_SECONDARY : fct_pkg::FCT_MOD_FILLER;
            s2_next = want_disp ? fct_pkg::FCT_MOD_DISPLAY : fct_pkg::FCT_MOD_FILLER;
            cfg_valid_next = 1'b1;
        end
    end

    // ----------------------------------------
    // Display telegram sender
    // ----------------------------------------
    logic [39:0] tx_reg, tx_next;
    logic [3:0] tidx_reg, tidx_next, oidx_reg, oidx_next;
    logic disp_busy_next, ov_reg, ov_next, olast_reg, olast_next;
    logic [7:0] ob_reg, ob_next;
    always_comb begin
        tx_next = tx_reg;
        tidx_next = tidx_reg;
        disp_busy_next = disp_busy;
        ov_next = 1'b0;
        olast_next = 1'b0;
        ob_next = ob_reg;
        oidx_next = oidx_reg;
        if (!disp_busy && disp_send) begin
            tx_next = {disp_value, disp_status};
            tidx_next = 4'h0;
            disp_busy_next = 1'b1;
        end else if (disp_busy) begin
            ov_next = 1'b1;
            oidx_next = tidx_reg;
            ob_next = tx_reg[39:32];
            tx_next = {tx_reg[31:0], 8'h00};
            olast_next = (tidx_reg == `FCT_OUT_LEN - 4'h1);
            tidx_next = tidx_reg + 4'h1;
            if (tidx_reg == `FCT_OUT_LEN - 4'h1) begin
                disp_busy_next = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Input telegram receiver
    // ----------------------------------------
    logic [31:0] acc_reg, acc_next, pri_next, sec_next;
    logic [7:0] pst_next, sst_next;
    logic rx_done_next;
    always_comb begin
        acc_next = acc_reg;
        pri_next = pri_value;
        sec_next = sec_value;
        pst_next = pri_status;
        sst_next = sec_status;
        rx_done_next = 1'b0;
        if (link.in_valid) begin
            if (link.in_index == `FCT_IN_PRI_STAT) begin
                pri_next = acc_reg;
                pst_next = link.in_byte;
            end else if (link.in_index == `FCT_IN_SEC_STAT) begin
                sec_next = acc_reg;
                sst_next = link.in_byte;
            end else begin
                acc_next = {acc_reg[23:0], link.in_byte};
            end
            rx_done_next = link.in_last;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= fct_pkg::FCT_MOD_FILLER;
            s2_reg <= fct_pkg::FCT_MOD_FILLER;
            cfg_valid_reg <= 1'b0;
            cfg_ok <= 1'b0;
            tx_reg <= 40'h0;
            tidx_reg <= 4'h0;
            disp_busy <= 1'b0;
            ov_reg <= 1'b0;
            olast_reg <= 1'b0;
            ob_reg <= 8'h00;
            oidx_reg <= 4'h0;
            acc_reg <= 32'h0;
            pri_value <= 32'h0;
            sec_value <= 32'h0;
            pri_status <= 8'h00;
            sec_status <= 8'h00;
            rx_done <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            cfg_valid_reg <= cfg_valid_next;
            cfg_ok <= cfg_ok_next;
            tx_reg <= tx_next;
            tidx_reg <= tidx_next;
            disp_busy <= disp_busy_next;
            ov_reg <= ov_next;
            olast_reg <= olast_next;
            ob_reg <= ob_next;
            oidx_reg <= oidx_next;
            acc_reg <= acc_next;
            pri_value <= pri_next;
            sec_value <= sec_next;
            pri_status <= pst_next;
            sec_status <= sst_next;
            rx_done <= rx_done_next;
        end
    end

    assign link.cfg_slot0 = fct_pkg::FCT_MOD_PRIMARY;
    assign link.cfg_slot1 = s1_reg;
    assign link.cfg_slot2 = s2_reg;
    assign link.cfg_valid = cfg_valid_reg;
    assign link.out_valid = ov_reg;
    assign link.out_index = oidx_reg;
    assign link.out_byte = ob_reg;
    assign link.out_last = olast_reg;
    // This end opens no acyclic sessions; the master avoids cyclic parameter writes
    assign link.ac_req = 1'b0;
    assign link.ac_sap = 8'h00;
    assign link.ac_open = 1'b0;
    assign link.ac_close = 1'b0;
    assign link.ac_slot = 8'h00;
    assign link.ac_index = 8'h00;
endmodule
`default_nettype wire

// ---- testbench/fct_link_sva.sv ----
// Concurrent checks on the link that joins the two ends, and on the acyclic lines of the lone device
`timescale 1ns/1ps
`default_nettype none
module fct_link_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire fct_pkg::fct_mod_e cfg_slot1,
    input wire fct_pkg::fct_mod_e cfg_slot2,
    input wire logic cfg_valid,
    input wire logic cfg_ok,
    input wire logic in_valid,
    input wire logic [3:0] in_index,
    input wire logic [7:0] in_byte,
    input wire logic in_last,
    input wire logic out_valid,
    input wire logic [3:0] out_index,
    input wire logic out_last,
    input wire logic ac_req,
    input wire logic [7:0] ac_sap,
    input wire logic ac_accept
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----
    // Configuration, telegram framing and acyclic access
    // ----
    sequence in_mid_s; in_valid && !in_last; endsequence
    sequence in_step_s; in_valid && in_index == $past(in_index) + 4'h1; endsequence
    sequence out_head_s; out_valid && out_index == 4'h0 && !out_last; endsequence
    sequence out_tail_s; out_valid[*3] ##1 (out_valid && out_last && out_index == 4'h4); endsequence
    cfg_legal_a: assert property (cfg_valid
        && cfg_slot1 inside {fct_pkg::FCT_MOD_SECONDARY, fct_pkg::FCT_MOD_FILLER}
        && cfg_slot2 inside {fct_pkg::FCT_MOD_DISPLAY, fct_pkg::FCT_MOD_FILLER} |=> cfg_ok)
        else $error("legal slot order refused");
    in_first_a: assert property ($rose(in_valid) |-> in_index == 4'h0)
        else $error("input telegram does not start at index zero");
    in_step_a: assert property (in_mid_s |=> in_step_s)
        else $error("input bytes not consecutive");
    in_end_a: assert property (in_valid && in_last |-> in_index == 4'h4 || in_index == 4'h9)
        else $error("input telegram ends at wrong index");
    pri_code_a: assert property (in_valid && in_index == 4'h4 |-> in_byte inside
        {8'h0f, 8'h1f, 8'h47, 8'h4b, 8'h4f, 8'h5c, 8'h80, 8'h84, 8'h89, 8'h8a, 8'h8d, 8'h8e})
        else $error("primary status code not allowed");
    sec_code_a: assert property (in_valid && in_index == 4'h9 |-> in_byte inside {8'h0c, 8'h40, 8'h80})
        else $error("secondary status code not allowed");
    out_frame_a: assert property (out_head_s |=> out_tail_s)
        else $error("display telegram not five consecutive bytes");
    no_class1_a: assert property (ac_req && ac_sap == 8'h33 |=> !ac_accept)
        else $error("session opened on reserved access point");
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Both ends joined by the link, plus a lone device for acyclic sessions
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    int err_count = 0;
    int comparisons = 0;
    logic [31:0] pv = '0, sv = '0, dv = '0;
    logic [7:0] ds = '0;
    logic send = 1'b0, ws = 1'b0, wd = 1'b0, cs = 1'b0, dsend = 1'b0;
    fct_pkg::fct_pri_cond_e pc = fct_pkg::FCT_PS_PRI_OK;
    fct_pkg::fct_sec_cond_e sc = fct_pkg::FCT_SC_OK;
    wire logic sec_en, disp_en, d_err, d_upd, grant, dbusy, rxd, mok, d_busy;
    wire logic [31:0] d_val, m_pv, m_sv;
    wire logic [7:0] d_st, m_ps, m_ss, slot_o, idx_o;
    wire logic [1:0] sess;
    fct_link_if link();
    fct_link_if link2();
    always #10 clk = ~clk;
    fct_device i_fct_device (.clk(clk), .rstn(rstn), .link(link), .pri_value(pv), .pri_cond(pc), .sec_value(sv),
        .sec_cond(sc), .send_start(send), .busy(d_busy), .sec_enabled(sec_en), .disp_enabled(disp_en),
        .disp_value(d_val),
        .disp_status(d_st), .disp_error(d_err), .disp_update(d_upd), .ac_grant(), .ac_slot_out(), .ac_index_out(),
        .sessions());
    // Second device alone: the master end holds the acyclic lines low
    fct_device i_fct_device_2 (.clk(clk), .rstn(rstn), .link(link2), .pri_value(pv), .pri_cond(pc),
        .sec_value(sv), .sec_cond(sc), .send_start(1'b0), .busy(), .sec_enabled(), .disp_enabled(), .disp_value(),
        .disp_status(), .disp_error(), .disp_update(), .ac_grant(grant), .ac_slot_out(slot_o), .ac_index_out(idx_o),
        .sessions(sess));
    fct_master i_fct_master (.clk(clk), .rstn(rstn), .link(link), .want_sec(ws), .want_disp(wd), .cfg_start(cs),
        .disp_value(dv), .disp_status(ds), .disp_send(dsend), .disp_busy(dbusy), .pri_value(m_pv), .pri_status(m_ps),
        .sec_value(m_sv), .sec_status(m_ss), .rx_done(rxd), .cfg_ok(mok));
    // Acyclic lines are watched on the lone device, the only place requests are made
    fct_link_sva i_fct_link_sva (.clk(clk), .rstn(rstn), .cfg_slot1(link.cfg_slot1), .cfg_slot2(link.cfg_slot2),
        .cfg_valid(link.cfg_valid), .cfg_ok(link.cfg_ok), .in_valid(link.in_valid), .in_index(link.in_index),
        .in_byte(link.in_byte), .in_last(link.in_last), .out_valid(link.out_valid), .out_index(link.out_index),
        .out_last(link.out_last), .ac_req(link2.ac_req), .ac_sap(link2.ac_sap), .ac_accept(link2.ac_accept));
    // ----
    // Helpers
    // ----
    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_cfg(input logic s, input logic d);
        int i;
        ws = s;
        wd = d;
        cs = 1'b1;
        tick;
        cs = 1'b0;
        for (i = 0; i < 20 && link.cfg_valid !== 1'b1; i++) tick;
        chk({i < 20, link.cfg_slot1}, {1'b1, s ? fct_pkg::FCT_MOD_SECONDARY : fct_pkg::FCT_MOD_FILLER});
        chk(link.cfg_slot2, d ? fct_pkg::FCT_MOD_DISPLAY : fct_pkg::FCT_MOD_FILLER);
        tick;
        tick;
        chk({link.cfg_ok, mok, sec_en, disp_en}, {2'b11, s, d});
    endtask
    task automatic t_tx(input logic s);
        logic [7:0] b [10];
        logic [7:0] pcode [12] = '{8'h80, 8'h0f, 8'h1f, 8'h47, 8'h4b, 8'h4f, 8'h5c, 8'h84, 8'h89, 8'h8a, 8'h8d, 8'h8e};
        logic [7:0] scode [3] = '{8'h80, 8'h0c, 8'h40};
        int n, j;
        for (int i = 0; i < 12; i++) begin
            pv = 32'hc1a8_0000 + i;
            sv = 32'h3f80_0001 + i;
            pc = fct_pkg::fct_pri_cond_e'(i);
            sc = fct_pkg::fct_sec_cond_e'(i % 3);
            send = 1'b1;
            tick;
            send = 1'b0;
            chk(d_busy, 1'b1);
            n = 0;
            for (j = 0; j < 40 && rxd !== 1'b1; j++) begin
                tick;
                if (link.in_valid === 1'b1) begin
                    b[link.in_index] = link.in_byte;
                    n++;
                end
            end
            chk({j < 40, n[3:0]}, {1'b1, s ? 4'ha : 4'h5});
            chk({b[0], b[1], b[2], b[3]}, pv);
            chk({b[4], m_ps}, {2{pcode[i]}});
            chk(m_pv, pv);
            if (s) begin
                chk({b[5], b[6], b[7], b[8]}, sv);
                chk({b[9], m_ss}, {2{scode[i % 3]}});
                chk(m_sv, sv);
            end
            tick;
        end
    endtask
    task automatic t_disp(input logic en);
        logic [7:0] codes [5] = '{8'h80, 8'hbf, 8'hc0, 8'h47, 8'h0f};
        int j;
        for (int i = 0; i < 5; i++) begin
            dv = 32'h4248_0000 + i;
            ds = codes[i];
            dsend = 1'b1;
            tick;
            dsend = 1'b0;
            for (j = 0; j < 20 && d_upd !== 1'b1; j++) tick;
            chk(d_upd, en);
            if (en) begin
                chk(d_val, dv);
                chk(d_st, ds);
                tick;
                chk(d_err, ds[7:6] != 2'b10);
            end
            for (j = 0; j < 20 && dbusy !== 1'b0; j++) tick;
            tick;
        end
    endtask
    // A legal layout first, so that a refused one visibly drops cfg_ok
    task automatic t_bad;
        for (int k = 0; k < 2; k++) begin
            link2.cfg_slot1 = (k == 0) ? fct_pkg::FCT_MOD_SECONDARY : fct_pkg::FCT_MOD_DISPLAY;
            link2.cfg_valid = 1'b1;
            tick;
            link2.cfg_valid = 1'b0;
            chk(link2.cfg_ok, k == 0);
            tick;
        end
    endtask
    task automatic t_ac(input logic [7:0] sap, input logic op, input logic cl, input logic acc, input logic [1:0] ns);
        link2.ac_req = 1'b1;
        link2.ac_sap = sap;
        link2.ac_open = op;
        link2.ac_close = cl;
        tick;
        link2.ac_req = 1'b0;
        chk({link2.ac_ack, link2.ac_accept, sess}, {1'b1, acc, ns});
        if (!op && !cl) begin
            chk({grant, slot_o, idx_o}, {acc, 16'h011a});
        end
        tick;
    endtask
    initial begin
        link2.cfg_slot0 = fct_pkg::FCT_MOD_PRIMARY;
        link2.cfg_slot1 = fct_pkg::FCT_MOD_FILLER;
        link2.cfg_slot2 = fct_pkg::FCT_MOD_FILLER;
        link2.cfg_valid = 1'b0;
        link2.out_valid = 1'b0;
        link2.out_index = 4'h0;
        link2.out_byte = 8'h00;
        link2.out_last = 1'b0;
        link2.ac_req = 1'b0;
        link2.ac_sap = 8'h00;
        link2.ac_open = 1'b0;
        link2.ac_close = 1'b0;
        link2.ac_slot = 8'h01;
        link2.ac_index = 8'h1a;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        for (int k = 0; k < 4; k++) t_cfg(k[0], k[1]);
        t_tx(1'b1);
        t_disp(1'b1);
        t_cfg(1'b0, 1'b0);
        t_tx(1'b0);
        t_disp(1'b0);
        t_bad;
        t_ac(8'h33, 1'b1, 1'b0, 1'b0, 2'h0);
        t_ac(8'h10, 1'b1, 1'b0, 1'b1, 2'h1);
        t_ac(8'h11, 1'b0, 1'b0, 1'b1, 2'h1);
        t_ac(8'h12, 1'b1, 1'b0, 1'b1, 2'h2);
        t_ac(8'h13, 1'b1, 1'b0, 1'b0, 2'h2);
        t_ac(8'h10, 1'b0, 1'b1, 1'b1, 2'h1);
        t_ac(8'h12, 1'b0, 1'b1, 1'b1, 2'h0);
        t_ac(8'h10, 1'b0, 1'b1, 1'b0, 2'h0);
        t_ac(8'h11, 1'b0, 1'b0, 1'b0, 2'h0);
        summarize;
    end
    // Whole run needs about 500 cycles; twenty times that means a hang
    initial begin
        #200000;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize;
    end
endmodule
`default_nettype wire
